/* File: rtl/dcg_top.sv */
// dcg_top: gain and offset code bank for the odd and even channels.
// assumes an AXI4-Lite master on aclk; codes feed the analogue channels.
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module dcg_top
    import dcg_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`DCG_AW-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [`DCG_AW-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic [`DCG_DW-1:0] odd_offset_code,
    output logic [`DCG_DW-1:0] even_offset_code,
    output logic [`DCG_DW:0] odd_gain_code,
    output logic [`DCG_DW:0] even_gain_code
);
    dcg_bus_if bus ();

    dcg_regs_type regs_r;
    dcg_regs_type regs_nxt;
    dcg_regs_type regs_dflt;
    logic wr_go;

    ////////////////////////////////////////////////////////////////////////
    // bus channels

    dcg_axil_wr u_wr (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .bus(bus.wr_src)
    );

    dcg_axil_rd u_rd (
        .aclk(aclk),
        .aresetn(aresetn),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .bus(bus.rd_src)
    );

    ////////////////////////////////////////////////////////////////////////
    // register bank

    // default image, shared by hard and soft reset
    always_comb begin
        regs_dflt.odd_off = `DCG_RST_ODD_OFF;
        regs_dflt.even_off = `DCG_RST_EVEN_OFF;
        regs_dflt.odd_msb = `DCG_RST_MSB;
        regs_dflt.even_msb = `DCG_RST_MSB;
        regs_dflt.odd_lsb = `DCG_RST_LSB;
        regs_dflt.even_lsb = `DCG_RST_LSB;
    end

    // only byte lane 0 carries data; a data write without it stores nothing
    assign wr_go = bus.wr_en && bus.wr_strb;

    // next bank value from the decoded write
    always_comb begin
        regs_nxt = regs_r;
        if (wr_go) begin
            case (bus.wr_idx)
                `DCG_IDX_ODD_OFF: begin
                    regs_nxt.odd_off = bus.wr_data;
                end
                `DCG_IDX_EVEN_OFF: begin
                    regs_nxt.even_off = bus.wr_data;
                end
                `DCG_IDX_BOTH_OFF: begin
                    regs_nxt.odd_off = bus.wr_data;
                    regs_nxt.even_off = bus.wr_data;
                end
                // upper bits of the low-bit words are dropped on purpose
                `DCG_IDX_ODD_LSB: begin
                    regs_nxt.odd_lsb = bus.wr_data[`DCG_LSB_POS];
                end
                `DCG_IDX_EVEN_LSB: begin
                    regs_nxt.even_lsb = bus.wr_data[`DCG_LSB_POS];
                end
                `DCG_IDX_BOTH_LSB: begin
                    regs_nxt.odd_lsb = bus.wr_data[`DCG_LSB_POS];
                    regs_nxt.even_lsb = bus.wr_data[`DCG_LSB_POS];
                end
                `DCG_IDX_ODD_MSB: begin
                    regs_nxt.odd_msb = bus.wr_data;
                end
                `DCG_IDX_EVEN_MSB: begin
                    regs_nxt.even_msb = bus.wr_data;
                end
                `DCG_IDX_BOTH_MSB: begin
                    regs_nxt.odd_msb = bus.wr_data;
                    regs_nxt.even_msb = bus.wr_data;
                end
                default: begin
                    regs_nxt = regs_r;
                end
            endcase
        end
        // soft reset ignores the strobe: the data value does not matter
        if (bus.wr_en && bus.wr_idx == `DCG_IDX_SRST) begin
            regs_nxt = regs_dflt;
        end
        if (!aresetn) begin
            regs_nxt = regs_dflt;
        end
    end

    always_ff @(posedge aclk) begin
        regs_r <= regs_nxt;
    end

    ////////////////////////////////////////////////////////////////////////
    // read back; broadcast and soft reset words are write only, read zero

    always_comb begin
        case (bus.rd_idx)
            `DCG_IDX_ODD_OFF: begin
                bus.rd_data = regs_r.odd_off;
            end
            `DCG_IDX_EVEN_OFF: begin
                bus.rd_data = regs_r.even_off;
            end
            `DCG_IDX_ODD_LSB: begin
                bus.rd_data = {7'h00, regs_r.odd_lsb};
            end
            `DCG_IDX_EVEN_LSB: begin
                bus.rd_data = {7'h00, regs_r.even_lsb};
            end
            `DCG_IDX_ODD_MSB: begin
                bus.rd_data = regs_r.odd_msb;
            end
            `DCG_IDX_EVEN_MSB: begin
                bus.rd_data = regs_r.even_msb;
            end
            default: begin
                bus.rd_data = 8'h00;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // codes to the analogue channels; gain is linear in the 9-bit code

    assign odd_offset_code = regs_r.odd_off;
    assign even_offset_code = regs_r.even_off;
    assign odd_gain_code = {regs_r.odd_msb, regs_r.odd_lsb};
    assign even_gain_code = {regs_r.even_msb, regs_r.even_lsb};

    ////////////////////////////////////////////////////////////////////////
    // checks

    a_odd_off_reset: assert property (
        @(posedge aclk) disable iff (!aresetn)
        $rose(aresetn) |-> odd_offset_code == `DCG_RST_ODD_OFF)
        else $error("odd offset not at default after reset");

    a_even_off_reset: assert property (
        @(posedge aclk) disable iff (!aresetn)
        $rose(aresetn) |-> even_offset_code == `DCG_RST_EVEN_OFF)
        else $error("even offset not at default after reset");

    a_even_off_alone: assert property (
        @(posedge aclk) disable iff (!aresetn)
        wr_go && bus.wr_idx == `DCG_IDX_ODD_OFF
        |=> even_offset_code == $past(even_offset_code)
            && odd_offset_code == $past(bus.wr_data))
        else $error("odd offset write disturbed even channel");

    a_both_off_load: assert property (
        @(posedge aclk) disable iff (!aresetn)
        wr_go && bus.wr_idx == `DCG_IDX_BOTH_OFF
        |=> odd_offset_code == $past(bus.wr_data)
            && even_offset_code == $past(bus.wr_data))
        else $error("offset broadcast missed a channel");

    a_odd_gain_join: assert property (
        @(posedge aclk) disable iff (!aresetn)
        wr_go && bus.wr_idx == `DCG_IDX_ODD_MSB
        |=> odd_gain_code[`DCG_DW:1] == $past(bus.wr_data)
            && odd_gain_code[0] == $past(odd_gain_code[0]))
        else $error("odd gain upper byte misplaced");

    a_even_gain_join: assert property (
        @(posedge aclk) disable iff (!aresetn)
        wr_go && bus.wr_idx == `DCG_IDX_EVEN_LSB
        |=> even_gain_code[0] == $past(bus.wr_data[0])
            && even_gain_code[`DCG_DW:1] == $past(even_gain_code[`DCG_DW:1]))
        else $error("even gain low bit misplaced");

    a_both_lsb_load: assert property (
        @(posedge aclk) disable iff (!aresetn)
        wr_go && bus.wr_idx == `DCG_IDX_BOTH_LSB
        |=> odd_gain_code[0] == $past(bus.wr_data[0])
            && even_gain_code[0] == $past(bus.wr_data[0]))
        else $error("gain low bit broadcast missed a channel");

    a_gain_msb_reset: assert property (
        @(posedge aclk) disable iff (!aresetn)
        $rose(aresetn) |-> odd_gain_code == {`DCG_RST_MSB, `DCG_RST_LSB}
            && even_gain_code == {`DCG_RST_MSB, `DCG_RST_LSB})
        else $error("gain codes not at default after reset");

    a_both_msb_load: assert property (
        @(posedge aclk) disable iff (!aresetn)
        wr_go && bus.wr_idx == `DCG_IDX_BOTH_MSB
        |=> odd_gain_code[`DCG_DW:1] == $past(bus.wr_data)
            && even_gain_code[`DCG_DW:1] == $past(bus.wr_data))
        else $error("gain upper broadcast missed a channel");

    a_soft_reset_all: assert property (
        @(posedge aclk) disable iff (!aresetn)
        bus.wr_en && bus.wr_idx == `DCG_IDX_SRST
        |=> odd_offset_code == `DCG_RST_ODD_OFF
            && even_offset_code == `DCG_RST_EVEN_OFF
            && odd_gain_code == {`DCG_RST_MSB, `DCG_RST_LSB}
            && even_gain_code == {`DCG_RST_MSB, `DCG_RST_LSB})
        else $error("soft reset left a code off default");

    a_lsb_read_zero: assert property (
        @(posedge aclk) disable iff (!aresetn)
        arvalid && arready
            && (bus.rd_idx == `DCG_IDX_ODD_LSB || bus.rd_idx == `DCG_IDX_EVEN_LSB)
        |=> rvalid && rdata[31:1] == 31'h00000000)
        else $error("unused low-bit register bits read nonzero");

    a_write_answer: assert property (
        @(posedge aclk) disable iff (!aresetn)
        bus.wr_en |=> bvalid ##0 !awready && !wready)
        else $error("write response late or channels open");

    a_odd_off_kept: assert property (
        @(posedge aclk) disable iff (!aresetn)
        wr_go && bus.wr_idx == `DCG_IDX_EVEN_OFF
        |=> odd_offset_code == $past(odd_offset_code)
            && even_offset_code == $past(bus.wr_data))
        else $error("even offset write disturbed odd channel");

    a_odd_lsb_load: assert property (
        @(posedge aclk) disable iff (!aresetn)
        wr_go && bus.wr_idx == `DCG_IDX_ODD_LSB
        |=> odd_gain_code[0] == $past(bus.wr_data[0])
            && odd_gain_code[`DCG_DW:1] == $past(odd_gain_code[`DCG_DW:1]))
        else $error("odd gain low bit misplaced");

    a_even_msb_load: assert property (
        @(posedge aclk) disable iff (!aresetn)
        wr_go && bus.wr_idx == `DCG_IDX_EVEN_MSB
        |=> even_gain_code[`DCG_DW:1] == $past(bus.wr_data)
            && even_gain_code[0] == $past(even_gain_code[0]))
        else $error("even gain upper byte misplaced");

    // a data write without lane 0 is answered but must store nothing
    a_strobe_off_hold: assert property (
        @(posedge aclk) disable iff (!aresetn)
        bus.wr_en && !bus.wr_strb && bus.wr_idx != `DCG_IDX_SRST
        |=> $stable(odd_offset_code) && $stable(even_offset_code)
            && $stable(odd_gain_code) && $stable(even_gain_code))
        else $error("write without lane 0 changed a code");

    a_read_answer: assert property (
        @(posedge aclk) disable iff (!aresetn)
        arvalid && arready |=> rvalid && !arready)
        else $error("read data late or address channel open");

    a_resp_held: assert property (
        @(posedge aclk) disable iff (!aresetn)
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped before taken");

    a_rdata_held: assert property (
        @(posedge aclk) disable iff (!aresetn)
        rvalid && !rready
        |=> rvalid && $stable(rdata) && $stable(rresp))
        else $error("read data dropped before taken");
endmodule : dcg_top
`default_nettype wire

/* File: shared/dcg_cfg.svh */
// dcg_cfg.svh: offsets, reset values and field positions of the
// dual channel gain/offset register bank.
// assumes AXI4-Lite word addressing: byte address is four times the index.
`ifndef DCG_CFG_SVH
`define DCG_CFG_SVH
`define DCG_DW 8
`define DCG_AW 12
`define DCG_IW 10
`define DCG_IDX_LO 2
`define DCG_IDX_SRST 10'h000
`define DCG_IDX_ODD_OFF 10'h020
`define DCG_IDX_EVEN_OFF 10'h021
`define DCG_IDX_BOTH_OFF 10'h022
`define DCG_IDX_ODD_LSB 10'h024
`define DCG_IDX_EVEN_LSB 10'h025
`define DCG_IDX_BOTH_LSB 10'h026
`define DCG_IDX_ODD_MSB 10'h028
`define DCG_IDX_EVEN_MSB 10'h029
`define DCG_IDX_BOTH_MSB 10'h02A
`define DCG_RST_ODD_OFF 8'h40
`define DCG_RST_EVEN_OFF 8'h80
`define DCG_RST_LSB 1'h0
`define DCG_RST_MSB 8'h0C
`define DCG_LSB_POS 0
`define DCG_RESP_OKAY 2'h0
`define DCG_RESP_SLVERR 2'h2
`endif

/* File: shared/dcg_pkg.sv */
// dcg_pkg: types and address decode of the gain/offset register bank.
// assumes dcg_cfg.svh is on the include path.
`default_nettype none
package dcg_pkg;
`include "dcg_cfg.svh"
    typedef logic [`DCG_DW-1:0] dcg_byte_type;
    typedef logic [`DCG_IW-1:0] dcg_idx_type;
    typedef logic [`DCG_AW-1:0] dcg_addr_type;

    // all bank state, one flop group
    typedef struct packed {
        dcg_byte_type odd_off;
        dcg_byte_type even_off;
        dcg_byte_type odd_msb;
        dcg_byte_type even_msb;
        logic odd_lsb;
        logic even_lsb;
    } dcg_regs_type;

    // word index of a byte address
    function automatic dcg_idx_type dcg_index(input dcg_addr_type a);
        return a[`DCG_AW-1:`DCG_IDX_LO];
    endfunction : dcg_index

    // decoded on both the write and the read side
    function automatic logic dcg_mapped(input dcg_idx_type i);
        case (i)
            `DCG_IDX_SRST, `DCG_IDX_ODD_OFF, `DCG_IDX_EVEN_OFF,
            `DCG_IDX_BOTH_OFF, `DCG_IDX_ODD_LSB, `DCG_IDX_EVEN_LSB,
            `DCG_IDX_BOTH_LSB, `DCG_IDX_ODD_MSB, `DCG_IDX_EVEN_MSB,
            `DCG_IDX_BOTH_MSB: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : dcg_mapped
endpackage : dcg_pkg
`default_nettype wire

/* File: shared/dcg_bus_if.sv */
// dcg_bus_if: internal register access between the AXI channels and the bank.
// assumes one clock; the write enable is a one-cycle pulse.
`timescale 1ns/10ps
`default_nettype none
interface dcg_bus_if;
    import dcg_pkg::*;
    logic wr_en;
    dcg_idx_type wr_idx;
    dcg_byte_type wr_data;
    logic wr_strb;
    dcg_idx_type rd_idx;
    dcg_byte_type rd_data;
    modport wr_src (output wr_en, output wr_idx, output wr_data, output wr_strb);
    modport rd_src (output rd_idx, input rd_data);
    modport bank (input wr_en, input wr_idx, input wr_data, input wr_strb,
                  input rd_idx, output rd_data);
endinterface : dcg_bus_if
`default_nettype wire

/* File: rtl/dcg_axil_wr.sv */
// dcg_axil_wr: AXI4-Lite write address, data and response channels.
// assumes a master with one write under way at a time.
`timescale 1ns/10ps
`default_nettype none
module dcg_axil_wr
    import dcg_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`DCG_AW-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    dcg_bus_if.wr_src bus
);
    typedef struct packed {
        logic aw_got;
        logic w_got;
        dcg_idx_type idx;
        dcg_byte_type data;
        logic strb;
        logic bvalid;
        logic [1:0] bresp;
    } dcg_wr_type;

    dcg_wr_type s_r;
    dcg_wr_type s_nxt;

    ////////////////////////////////////////////////////////////////////////
    // channels taken in either order; held off while a response waits
    always_comb begin
        s_nxt = s_r;
        awready = !s_r.aw_got && !s_r.bvalid;
        wready = !s_r.w_got && !s_r.bvalid;
        bus.wr_en = s_r.aw_got && s_r.w_got;
        bus.wr_idx = s_r.idx;
        bus.wr_data = s_r.data;
        bus.wr_strb = s_r.strb;
        if (awvalid && awready) begin
            s_nxt.aw_got = 1'b1;
            s_nxt.idx = dcg_index(awaddr);
        end
        if (wvalid && wready) begin
            s_nxt.w_got = 1'b1;
            s_nxt.data = wdata[`DCG_DW-1:0];
            s_nxt.strb = wstrb[0];
        end
        if (bus.wr_en) begin
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = dcg_mapped(s_r.idx) ? `DCG_RESP_OKAY : `DCG_RESP_SLVERR;
        end
        if (s_r.bvalid && bready) begin
            s_nxt.bvalid = 1'b0;
        end
        if (!aresetn) begin
            s_nxt = '0;
        end
    end

    always_ff @(posedge aclk) begin
        s_r <= s_nxt;
    end

    assign bvalid = s_r.bvalid;
    assign bresp = s_r.bresp;
endmodule : dcg_axil_wr
`default_nettype wire

/* File: rtl/dcg_axil_rd.sv */
// dcg_axil_rd: AXI4-Lite read address and read data channels.
// assumes the bank answers its read index in the same cycle.
`timescale 1ns/10ps
`default_nettype none
module dcg_axil_rd
    import dcg_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`DCG_AW-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    dcg_bus_if.rd_src bus
);
    typedef struct packed {
        logic rvalid;
        dcg_byte_type rdata;
        logic [1:0] rresp;
    } dcg_rd_type;

    dcg_rd_type s_r;
    dcg_rd_type s_nxt;

    ////////////////////////////////////////////////////////////////////////
    // data captured on the address edge, so it cannot shift while held
    always_comb begin
        s_nxt = s_r;
        arready = !s_r.rvalid;
        bus.rd_idx = dcg_index(araddr);
        if (arvalid && arready) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata = bus.rd_data;
            s_nxt.rresp = dcg_mapped(bus.rd_idx) ? `DCG_RESP_OKAY : `DCG_RESP_SLVERR;
        end
        if (s_r.rvalid && rready) begin
            s_nxt.rvalid = 1'b0;
        end
        if (!aresetn) begin
            s_nxt = '0;
        end
    end

    always_ff @(posedge aclk) begin
        s_r <= s_nxt;
    end

    assign rvalid = s_r.rvalid;
    assign rresp = s_r.rresp;
    assign rdata = {24'h000000, s_r.rdata};
endmodule : dcg_axil_rd
`default_nettype wire

/* File: verification/dcg_host.sv */
// dcg_host: AXI4-Lite master model of the host on the register bus.
// assumes one clock; the bench calls wr and rd and may set lag.
`timescale 1ns/10ps
`default_nettype none
module dcg_host (
    input wire logic aclk,
    output logic [11:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    output logic bready,
    output logic [11:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    output logic rready,
    output logic hang
);
    int lag = 0; // cycles before the host takes an answer

    ////////////////////////////////////////////////////////////////////////////////
    // idle bus at time zero
    initial begin
        awaddr = 12'h000;
        awvalid = 1'b0;
        wdata = 32'h0000_0000;
        wstrb = 4'h0;
        wvalid = 1'b0;
        bready = 1'b0;
        araddr = 12'h000;
        arvalid = 1'b0;
        rready = 1'b0;
        hang = 1'b0;
    end

    // address and data offered together, each released when taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= (lag == 0);
        do begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) begin
                awvalid <= 1'b0;
                awaddr <= ~a; // released lines never keep the old value
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
                wdata <= ~d;
            end
            if (!bready && n >= lag) bready <= 1'b1;
        end while (!(bvalid && bready) && n < 50);
        if (bvalid && bready) bready <= 1'b0;
        else hang <= 1'b1;
    endtask : wr

    // one read at a time; rready may lag to stall the slave
    task automatic rd(input logic [11:0] a);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= (lag == 0);
        do begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) begin
                arvalid <= 1'b0;
                araddr <= ~a;
            end
            if (!rready && n >= lag) rready <= 1'b1;
        end while (!(rvalid && rready) && n < 50);
        if (rvalid && rready) rready <= 1'b0;
        else hang <= 1'b1;
    endtask : rd
endmodule : dcg_host
`default_nettype wire

/* File: verification/tb_dual_channel_gain_offset_regs.sv */
// tb_dual_channel_gain_offset_regs: self-checking bench for dcg_top.
// assumes dcg_host drives the bus; a shadow copy predicts every answer.
`timescale 1ns/10ps
`default_nettype none
`include "dcg_cfg.svh"
module tb_dual_channel_gain_offset_regs
    import dcg_pkg::*;
;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, hang;
    logic arvalid, arready, rvalid, rready;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [7:0] odd_offset_code, even_offset_code, oo, eo, om, em;
    logic [8:0] odd_gain_code, even_gain_code;
    logic ol, el;
    logic [33:0] exp_r[$];
    logic [1:0] exp_b[$];
    int mismatches = 0;
    int total_checks = 0;
    int seed;
    logic [9:0] idx_list [12] = '{10'h000, 10'h020, 10'h021, 10'h022, 10'h023, 10'h024,
                                  10'h025, 10'h026, 10'h028, 10'h029, 10'h02A, 10'h3FF};

    dcg_top dut_u (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .odd_offset_code(odd_offset_code),
        .even_offset_code(even_offset_code), .odd_gain_code(odd_gain_code),
        .even_gain_code(even_gain_code)
    );
    dcg_host host_u (
        .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rvalid(rvalid), .rready(rready), .hang(hang)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // 125 MHz clock
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run

    // shadow defaults, shared by power-on and soft reset
    task automatic sh_rst();
        oo = 8'h40;
        eo = 8'h80;
        {om, em} = {8'h0C, 8'h0C};
        {ol, el} = 2'b00;
    endtask : sh_rst

    task automatic chk_outs();
        check({26'h0, odd_offset_code}, {26'h0, oo});
        check({26'h0, even_offset_code}, {26'h0, eo});
        check({25'h0, odd_gain_code}, {25'h0, om, ol});
        check({25'h0, even_gain_code}, {25'h0, em, el});
    endtask : chk_outs

    // predict the write, note its response, run it, then look at the codes
    task automatic do_wr(input logic [9:0] i, input logic [31:0] d, input logic [3:0] s);
        logic [1:0] r;
        r = `DCG_RESP_OKAY;
        case (i)
            10'h000: sh_rst();
            10'h020: if (s[0]) oo = d[7:0];
            10'h021: if (s[0]) eo = d[7:0];
            10'h022: if (s[0]) {oo, eo} = {d[7:0], d[7:0]};
            10'h024: if (s[0]) ol = d[0];
            10'h025: if (s[0]) el = d[0];
            10'h026: if (s[0]) {ol, el} = {d[0], d[0]};
            10'h028: if (s[0]) om = d[7:0];
            10'h029: if (s[0]) em = d[7:0];
            10'h02A: if (s[0]) {om, em} = {d[7:0], d[7:0]};
            default: r = `DCG_RESP_SLVERR;
        endcase
        exp_b.push_back(r);
        host_u.wr({i, 2'b00}, d, s);
        chk_outs();
    endtask : do_wr

    task automatic do_rd(input logic [9:0] i);
        logic [7:0] v;
        logic [1:0] r;
        v = 8'h00;
        r = `DCG_RESP_OKAY;
        case (i)
            10'h020: v = oo;
            10'h021: v = eo;
            10'h024: v = {7'h00, ol};
            10'h025: v = {7'h00, el};
            10'h028: v = om;
            10'h029: v = em;
            10'h000, 10'h022, 10'h026, 10'h02A: v = 8'h00;
            default: r = `DCG_RESP_SLVERR;
        endcase
        exp_r.push_back({r, 24'h000000, v});
        host_u.rd({i, 2'b00});
    endtask : do_rd

    // every mapped word and two unmapped ones, back to back
    task automatic rd_all();
        foreach (idx_list[k]) do_rd(idx_list[k]);
    endtask : rd_all

    // answer watcher: oldest note against each accepted response
    always @(posedge aclk) begin
        if (rvalid && rready) check({rresp, rdata}, exp_r.pop_front());
        if (bvalid && bready) check({32'h0, bresp}, {32'h0, exp_b.pop_front()});
        if (hang === 1'b1) begin
            mismatches++;
            complete_run();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 53184;
        aresetn = 1'b0;
        sh_rst();
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk_outs();
        rd_all();
        $display("test reset_values done");
        // random bytes per channel; the bench keeps low-bit words' bits 7:1 at zero
        for (int k = 0; k < 4; k++) begin
            do_wr(10'h020, $random(seed), 4'hF);
            do_wr(10'h021, $random(seed), 4'hF);
            do_wr(10'h024, $random(seed) & 32'h0000_0001, 4'hF);
            do_wr(10'h025, $random(seed) & 32'h0000_0001, 4'hF);
            do_wr(10'h028, $random(seed), 4'hF);
            do_wr(10'h029, $random(seed), 4'hF);
            rd_all();
        end
        $display("test channel_writes done");
        // slow host; gain code driven to both ends, 0 and 511
        host_u.lag = 3;
        do_wr(10'h022, $random(seed), 4'hF);
        do_wr(10'h026, 32'h0000_0000, 4'hF);
        do_wr(10'h02A, 32'h0000_0000, 4'hF);
        do_wr(10'h026, 32'h0000_0001, 4'hF);
        do_wr(10'h02A, 32'h0000_00FF, 4'hF);
        rd_all();
        host_u.lag = 0;
        $display("test broadcasts done");
        // strobe off and unmapped words leave the bank alone
        do_wr(10'h020, 32'h0000_0011, 4'h0);
        do_wr(10'h023, 32'h0000_0022, 4'hF);
        do_wr(10'h3FF, 32'h0000_0033, 4'hF);
        rd_all();
        $display("test refused_writes done");
        // soft reset: strobe and data do not matter
        do_wr(10'h000, $random(seed), 4'h0);
        rd_all();
        $display("test soft_reset done");
        repeat (4) @(posedge aclk);
        check(34'(exp_r.size() + exp_b.size()), 34'h0);
        complete_run();
    end
endmodule : tb_dual_channel_gain_offset_regs
`default_nettype wire
